// *** rtl/spicf_cfg.svh ***
// Register map, field positions, reset values and sizes of the serial port configuration block
`ifndef SPICF_CFG_SVH
`define SPICF_CFG_SVH
// Register byte offsets
`define SPICF_OFF_CTRL1 12'h000
`define SPICF_OFF_CTRL2 12'h004
`define SPICF_OFF_DATA 12'h008
`define SPICF_OFF_STAT 12'h00c
`define SPICF_OFF_EVT 12'h010
`define SPICF_OFF_EVT_CLR 12'h014
`define SPICF_OFF_EVT_EN 12'h018
// Control one field positions
`define SPICF_C1_EDGE 8
`define SPICF_C1_SLAVE_SELECT_ENABLE 7
`define SPICF_C1_POL 6
`define SPICF_C1_MST 5
`define SPICF_C1_SEC_HI 4
`define SPICF_C1_SEC_LO 2
`define SPICF_C1_PRI_HI 1
`define SPICF_C1_PRI_LO 0
// Control two field positions
`define SPICF_C2_FRM 15
`define SPICF_C2_FSD 14
`define SPICF_C2_FPOL 13
`define SPICF_C2_FEDGE 1
`define SPICF_C2_EBUF 0
// Writable bits and reset values
`define SPICF_C1_WMASK 16'h01ff
`define SPICF_C2_WMASK 16'he003
`define SPICF_CTRL_RST 16'h0000
// Status and event bit positions
`define SPICF_ST_RXFULL 0
`define SPICF_ST_BUSY 1
`define SPICF_EVT_DONE 0
`define SPICF_EVT_OVF 1
// Divider ratios
`define SPICF_PRI_R11 10'h001
`define SPICF_PRI_R10 10'h004
`define SPICF_PRI_R01 10'h010
`define SPICF_PRI_R00 10'h040
`define SPICF_SEC_BASE 10'h008
// Word and buffer sizes
`define SPICF_WORD_BITS 16
`define SPICF_RX_DEPTH 8
`endif

// *** rtl/spicf_pkg.sv ***
// Types shared by the serial port configuration block
`include "spicf_cfg.svh"
package spicf_pkg;
  // Transfer sequencer states
  typedef enum logic [1:0] {st_idle = 2'b00, st_sync = 2'b01, st_shift = 2'b10} spicf_mode_t;
  // Divider state
  typedef struct packed {
    logic [9:0] cnt;
  } spicf_div_t;
  // Receive queue state
  typedef struct packed {
    logic [`SPICF_RX_DEPTH-1:0][`SPICF_WORD_BITS-1:0] mem;
    logic [2:0] wr_ptr;
    logic [2:0] rd_ptr;
    logic [3:0] count;
  } spicf_rxq_t;
  // Core state
  typedef struct packed {
    logic [15:0] ctrl1;
    logic [15:0] ctrl2;
    logic [`SPICF_WORD_BITS-1:0] tx_hold;
    logic [`SPICF_WORD_BITS-1:0] sr;
    logic dout;
    logic sclk_act;
    logic fsync;
    logic clk_prev;
    spicf_mode_t mode;
    logic [4:0] bitcnt;
    logic [1:0] evt;
    logic [1:0] evt_en;
    logic [31:0] prdata;
  } spicf_core_t;
endpackage

// *** rtl/spicf_clkdiv.sv ***
// Master bit clock divider: primary times secondary ratio, leading and trailing edge ticks
`timescale 1ns/1ps
`default_nettype none
`include "spicf_cfg.svh"
module spicf_clkdiv (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Divider control
  input wire logic run,
  input wire logic [1:0] primary_divider,
  input wire logic [2:0] secondary_divider,
  // Bit clock edge ticks
  output logic lead_tick,
  output logic trail_tick
);
  spicf_pkg::spicf_div_t st, next_st;
  logic [9:0] pri_ratio; // Primary ratio
  logic [9:0] sec_ratio; // Secondary ratio
  logic [9:0] ratio; // Cycles per bit clock

  // Primary ratio lookup
  always_comb begin
    case (primary_divider)
      2'b11: pri_ratio = `SPICF_PRI_R11; // RQ2
      2'b10: pri_ratio = `SPICF_PRI_R10; // RQ2
      2'b01: pri_ratio = `SPICF_PRI_R01; // RQ2
      default: pri_ratio = `SPICF_PRI_R00; // RQ2
    endcase
  end
  assign sec_ratio = `SPICF_SEC_BASE - {7'h00, secondary_divider}; // RQ1
  assign ratio = 10'(pri_ratio * sec_ratio); // RQ11

  // Period counter; >= guards against a ratio shrinking mid-count
  always_comb begin
    next_st = st;
    if (!run || st.cnt >= ratio - 10'h001) begin
      next_st.cnt = 10'h000;
    end else begin
      next_st.cnt = st.cnt + 10'h001;
    end
  end
  // Ratio one puts both ticks in one cycle; that setting is not usable
  assign lead_tick = run && st.cnt == 10'h000;
  assign trail_tick = run && st.cnt == (ratio >> 1);

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // Helper: enabled cycles since the last leading tick
  logic [9:0] gap;
  logic gap_ok;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap <= 10'h000;
      gap_ok <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        gap_ok <= 1'b0;
      end else if (lead_tick) begin
        gap <= 10'h001;
        gap_ok <= 1'b1;
      end else begin
        gap <= gap + 10'h001;
      end
    end
  end
  lead_gap_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
    (ce && lead_tick && gap_ok && $stable(ratio)) |-> gap == ratio)
    else $error("bit clock period differs from divider product");
  sec_slow_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
    (primary_divider == 2'b11 && secondary_divider == 3'b000) |-> ratio == 10'h008)
    else $error("secondary zero does not divide by eight");
  pri_slow_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
    (primary_divider == 2'b00 && secondary_divider == 3'b111) |-> ratio == 10'h040)
    else $error("primary zero does not divide by sixty four");
endmodule
`default_nettype wire

// *** rtl/spicf_rxbuf.sv ***
// Receive word store: one entry in legacy mode, eight in enhanced mode
`timescale 1ns/1ps
`default_nettype none
`include "spicf_cfg.svh"
module spicf_rxbuf (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Mode
  input wire logic enhanced,
  // Shift side
  input wire logic push,
  input wire logic [`SPICF_WORD_BITS-1:0] push_data,
  output logic overflow,
  // Software side
  input wire logic pop,
  output logic [`SPICF_WORD_BITS-1:0] rd_data,
  output logic full
);
  spicf_pkg::spicf_rxq_t st, next_st;
  logic [3:0] limit; // Usable entries
  logic pop_ok; // Read of a held word
  logic accept; // Word stored

  assign limit = enhanced ? 4'(`SPICF_RX_DEPTH) : 4'h1; // RQ8
  assign full = st.count >= limit; // RQ9 RQ10
  assign pop_ok = pop && st.count != 4'h0;
  // A read in the same cycle frees room, so the word is kept
  assign accept = push && (!full || pop_ok);
  assign overflow = push && !accept;
  assign rd_data = st.mem[st.rd_ptr];

  // Queue update
  always_comb begin
    next_st = st;
    if (pop_ok) begin
      next_st.rd_ptr = st.rd_ptr + 3'h1;
    end
    if (accept) begin
      next_st.mem[st.wr_ptr] = push_data;
      next_st.wr_ptr = st.wr_ptr + 3'h1;
    end
    next_st.count = st.count + {3'h0, accept} - {3'h0, pop_ok};
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  legacy_set_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
    (ce && !enhanced && push && st.count == 4'h0) ##1 !enhanced |-> full)
    else $error("legacy word did not set full");
  legacy_clr_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
    (ce && !enhanced && pop && !push && st.count == 4'h1) ##1 !enhanced |-> !full)
    else $error("legacy read did not clear full");
  enh_fill_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
    (ce && enhanced && push && !pop && st.count == 4'h7) ##1 enhanced |-> full ##1 (!enhanced || full || $past(pop)))
    else $error("last entry fill did not set full");
  enh_room_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
    (ce && enhanced && push && !pop && st.count == 4'h1) ##1 enhanced |-> !full)
    else $error("enhanced mode held only one word");
endmodule
`default_nettype wire

// *** rtl/spicf_top.sv ***
// Serial port configuration core: APB registers, clock and frame control, word shifter
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "spicf_cfg.svh"
// How it works
// RQ1 - Secondary divides by eight minus field value
// RQ2 - Primary divides by 1, 4, 16, 64
// RQ3 - Framed mode ignores edge select; software clears
// RQ4 - Framed enable uses sync pulse on select
// RQ5 - Sync direction set means sync is input
// RQ6 - Sync polarity set means active high pulse
// RQ7 - Sync edge set coincides with first bit
// RQ8 - Enhanced enable selects eight word buffer
// RQ9 - Legacy full sets on word, clears on read
// RQ10 - Enhanced full on last entry, clears freed
// RQ11 - Bit rate is clock over divider product
// RQ12 - Polarity sets idle level; edge picks change
// RQ13 - Master enable drives clock, else follows
module spicf_top (
  // Clock, reset, clock enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial clock pin
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe_n,
  // Serial data pins
  input wire logic data_in_pin,
  output logic data_out_pin,
  output logic data_out_oe_n,
  // Slave select pin
  input wire logic slave_select_pin_in,
  output logic slave_select_pin_out,
  output logic slave_select_pin_oe_n,
  // Interrupt
  output logic irq
);
  localparam logic [4:0] LAST_BIT = 5'(`SPICF_WORD_BITS - 1);
  localparam logic [4:0] ALL_BITS = 5'(`SPICF_WORD_BITS);
  spicf_pkg::spicf_core_t st, next_st;

  // Control fields
  logic edge_sel, slave_select_enable, pol, master, framed, fsd, fpol, fedge, ebuf;
  logic [2:0] secondary_divider;
  logic [1:0] primary_divider;
  assign edge_sel = st.ctrl1[`SPICF_C1_EDGE];
  assign slave_select_enable = st.ctrl1[`SPICF_C1_SLAVE_SELECT_ENABLE];
  assign pol = st.ctrl1[`SPICF_C1_POL];
  assign master = st.ctrl1[`SPICF_C1_MST];
  assign secondary_divider = st.ctrl1[`SPICF_C1_SEC_HI:`SPICF_C1_SEC_LO];
  assign primary_divider = st.ctrl1[`SPICF_C1_PRI_HI:`SPICF_C1_PRI_LO];
  assign framed = st.ctrl2[`SPICF_C2_FRM];
  assign fsd = st.ctrl2[`SPICF_C2_FSD];
  assign fpol = st.ctrl2[`SPICF_C2_FPOL];
  assign fedge = st.ctrl2[`SPICF_C2_FEDGE];
  assign ebuf = st.ctrl2[`SPICF_C2_EBUF];

  // APB phases; zero wait states
  logic setup, wr, rd, mapped, wr_data;
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign wr_data = wr && paddr == `SPICF_OFF_DATA;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Bit clock events
  logic lead_m, trail_m, lead, trail, sample_ev, change_ev, cke_eff, clk_act_in, run;
  logic sync_act, selected, drive_start;
  // Edge select only counts outside framed mode; software keeps it clear there
  assign cke_eff = edge_sel && !framed; // RQ3
  assign clk_act_in = serial_clock_pin_in ^ pol; // RQ12
  // Frame slave with clock master keeps the clock running to catch sync
  assign run = master && (st.mode != spicf_pkg::st_idle || (framed && fsd)); // RQ13
  assign lead = master ? lead_m : (clk_act_in && !st.clk_prev); // RQ13
  assign trail = master ? (trail_m && !lead_m) : (!clk_act_in && st.clk_prev);
  assign sample_ev = cke_eff ? lead : trail; // RQ12
  assign change_ev = cke_eff ? trail : lead; // RQ12
  assign sync_act = slave_select_pin_in == fpol; // RQ6
  assign selected = !slave_select_enable || !slave_select_pin_in;
  // Software write starts a word when this end owns the start
  assign drive_start = wr_data && (framed ? !fsd : master); // RQ4 RQ5

  // Receive store
  logic rx_push, rx_full, rx_ovf;
  logic [`SPICF_WORD_BITS-1:0] rx_word;
  spicf_rxbuf u_rxbuf (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .enhanced(ebuf),
    .push(rx_push),
    .push_data({st.sr[`SPICF_WORD_BITS-2:0], data_in_pin}),
    .overflow(rx_ovf),
    .pop(rd && paddr == `SPICF_OFF_DATA),
    .rd_data(rx_word),
    .full(rx_full)
  );

  // Bit clock divider
  spicf_clkdiv u_clkdiv (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .run(run),
    .primary_divider(primary_divider),
    .secondary_divider(secondary_divider),
    .lead_tick(lead_m),
    .trail_tick(trail_m)
  );

  // Read mux, sampled in the setup phase
  logic [31:0] rd_mux;
  always_comb begin
    mapped = 1'b1;
    case (paddr)
      `SPICF_OFF_CTRL1: rd_mux = {16'h0000, st.ctrl1};
      `SPICF_OFF_CTRL2: rd_mux = {16'h0000, st.ctrl2};
      `SPICF_OFF_DATA: rd_mux = {16'h0000, rx_word};
      `SPICF_OFF_STAT: rd_mux = {30'h0, st.mode != spicf_pkg::st_idle, rx_full};
      `SPICF_OFF_EVT: rd_mux = {30'h0, st.evt};
      `SPICF_OFF_EVT_CLR: rd_mux = 32'h0000_0000;
      `SPICF_OFF_EVT_EN: rd_mux = {30'h0, st.evt_en};
      default: begin
        rd_mux = 32'h0000_0000;
        mapped = 1'b0;
      end
    endcase
  end

  // Next state
  always_comb begin
    next_st = st;
    rx_push = 1'b0;
    // Register writes
    if (setup) begin
      next_st.prdata = rd_mux;
    end
    if (wr && paddr == `SPICF_OFF_CTRL1) begin
      next_st.ctrl1 = pwdata[15:0] & `SPICF_C1_WMASK;
    end
    if (wr && paddr == `SPICF_OFF_CTRL2) begin
      next_st.ctrl2 = pwdata[15:0] & `SPICF_C2_WMASK;
    end
    if (wr_data) begin
      next_st.tx_hold = pwdata[`SPICF_WORD_BITS-1:0];
    end
    if (wr && paddr == `SPICF_OFF_EVT_EN) begin
      next_st.evt_en = pwdata[1:0];
    end
    next_st.clk_prev = clk_act_in;
    // Transfer sequencer
    case (st.mode)
      spicf_pkg::st_idle: begin
        next_st.bitcnt = 5'h00;
        if (drive_start) begin
          // Data change on trailing edge needs the first bit out now
          next_st.sr = pwdata[`SPICF_WORD_BITS-1:0];
          if (cke_eff) begin
            next_st.dout = pwdata[`SPICF_WORD_BITS-1];
          end
          next_st.mode = (framed && !fedge) ? spicf_pkg::st_sync : spicf_pkg::st_shift; // RQ7
        end else if (framed && fsd) begin
          // Frame slave waits for the sync pulse on a leading edge
          if (lead && sync_act) begin // RQ5
            next_st.sr = st.tx_hold;
            if (fedge) begin // RQ7
              next_st.mode = spicf_pkg::st_shift;
              next_st.dout = st.tx_hold[`SPICF_WORD_BITS-1];
            end else begin
              next_st.mode = spicf_pkg::st_sync;
              next_st.bitcnt = 5'h01;
            end
          end
        end else if (!master && !framed && selected) begin
          // Unframed slave arms as soon as it is selected
          next_st.sr = st.tx_hold;
          next_st.dout = st.tx_hold[`SPICF_WORD_BITS-1];
          next_st.mode = spicf_pkg::st_shift;
        end
      end
      spicf_pkg::st_sync: begin
        // One bit clock of sync ahead of the first data bit
        if (lead) begin // RQ7
          if (st.bitcnt == 5'h00) begin
            next_st.bitcnt = 5'h01;
          end else begin
            next_st.bitcnt = 5'h00;
            next_st.mode = spicf_pkg::st_shift;
            next_st.dout = st.sr[`SPICF_WORD_BITS-1];
          end
        end
      end
      spicf_pkg::st_shift: begin
        if (change_ev) begin
          next_st.dout = st.sr[`SPICF_WORD_BITS-1];
        end
        if (sample_ev) begin
          next_st.sr = {st.sr[`SPICF_WORD_BITS-2:0], data_in_pin};
          next_st.bitcnt = st.bitcnt + 5'h01;
          rx_push = st.bitcnt == LAST_BIT; // RQ9 RQ10
        end
        // Master finishes on a trailing edge so the clock ends idle
        if (master ? (trail && (st.bitcnt == ALL_BITS || (sample_ev && st.bitcnt == LAST_BIT)))
                   : (sample_ev && st.bitcnt == LAST_BIT)) begin
          next_st.mode = spicf_pkg::st_idle;
        end
        // Deselect aborts an unframed slave word
        if (!master && !framed && !selected) begin
          next_st.mode = spicf_pkg::st_idle;
        end
      end
      default: begin
        next_st.mode = spicf_pkg::st_idle;
      end
    endcase
    // Control write drops any word in flight; a stale slave arm must not run on as master
    if (wr && (paddr == `SPICF_OFF_CTRL1 || paddr == `SPICF_OFF_CTRL2)) begin // RQ13
      next_st.mode = spicf_pkg::st_idle;
    end
    // Master clock level; leading edge wins at ratio one
    if (next_st.mode == spicf_pkg::st_idle && !run) begin
      next_st.sclk_act = 1'b0;
    end else if (lead_m) begin
      next_st.sclk_act = 1'b1;
    end else if (trail_m) begin
      next_st.sclk_act = 1'b0;
    end
    // Frame sync drive, one bit clock wide ahead of the first bit, until the first sample edge when coincident with it
    next_st.fsync = framed && (next_st.mode == spicf_pkg::st_sync ||
                    (next_st.mode == spicf_pkg::st_shift && fedge && next_st.bitcnt == 5'h00)); // RQ4 RQ7
    // Sticky events; a new event beats a clear in the same cycle
    next_st.evt = st.evt & ~((wr && paddr == `SPICF_OFF_EVT_CLR) ? pwdata[1:0] : 2'b00);
    if (rx_push) begin
      next_st.evt[`SPICF_EVT_DONE] = 1'b1;
    end
    if (rx_ovf) begin
      next_st.evt[`SPICF_EVT_OVF] = 1'b1;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // Outputs
  assign prdata = st.prdata;
  assign serial_clock_pin_out = st.sclk_act ^ pol; // RQ12
  assign serial_clock_pin_oe_n = !master; // RQ13
  assign data_out_pin = st.dout;
  assign data_out_oe_n = !(master || framed || selected);
  assign slave_select_pin_out = st.fsync ? fpol : !fpol; // RQ6
  assign slave_select_pin_oe_n = !(framed && !fsd); // RQ5
  assign irq = |(st.evt & st.evt_en);

  // Frame master start sequences
  sequence frame_go_s;
    ce && st.mode == spicf_pkg::st_idle && wr_data && framed && !fsd;
  endsequence
  sequence cfg_hold_s;
    $stable(st.ctrl2) && $stable(st.ctrl1);
  endsequence
  early_sync_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
    (frame_go_s ##0 !fedge) ##1 cfg_hold_s |-> st.mode == spicf_pkg::st_sync && slave_select_pin_out == fpol)
    else $error("preceding sync pulse not started");
  same_sync_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
    (frame_go_s ##0 fedge) ##1 cfg_hold_s |-> st.mode == spicf_pkg::st_shift && st.fsync)
    else $error("coincident sync pulse not started");
  frame_pol_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ6 RQ5
    (framed && !fsd && st.fsync) |-> !slave_select_pin_oe_n && slave_select_pin_out == fpol)
    else $error("frame sync drive wrong");
  sync_wait_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
    (ce && st.mode == spicf_pkg::st_idle && framed && fsd && !sync_act) ##1 cfg_hold_s
    |-> st.mode == spicf_pkg::st_idle)
    else $error("frame slave started without sync");
  idle_level_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
    (master && !run && st.mode == spicf_pkg::st_idle) [*2] |-> serial_clock_pin_out == pol)
    else $error("serial clock not at idle level");
  slave_follow_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
    (ce && !master && st.mode == spicf_pkg::st_shift && clk_act_in == st.clk_prev) |=> $stable(st.bitcnt))
    else $error("slave counted a bit without clock edge");
endmodule
`default_nettype wire

// *** verification/spicf_peer.sv ***
// Behavioural far-side serial device answering master transfers
`timescale 1ns/1ps
`default_nettype none
module spicf_peer (
  // Serial link
  input wire logic sclk,
  input wire logic pol,
  input wire logic mosi,
  output logic miso
);
  // Reply word, captured word and bit count
  logic [15:0] tx_word = 16'h0000;
  logic [15:0] rx_word = 16'h0000;
  int bits = 16;
  initial miso = 1'b0;
  // Load a reply; the line flips so a stale level never passes for data
  task automatic arm(input logic [15:0] w);
    tx_word = w;
    bits = 0;
    miso = ~miso;
  endtask
  // Leaving idle presents a bit, returning to idle takes one, MSB first
  always @(sclk) begin
    if (bits < 16 && sclk === ~pol) begin
      miso = tx_word[15-bits];
    end else if (bits < 16 && sclk === pol) begin
      rx_word = {rx_word[14:0], mosi};
      bits++;
      // Released after the word: show the inverse, not the last bit
      if (bits == 16) begin
        miso = ~miso;
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/spicf_top_test.sv ***
// Self-checking bench for the serial port configuration core
`timescale 1ns/1ps
`default_nettype none
`include "spicf_cfg.svh"
module spicf_top_test;
  // Bus and pin drive
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, ss_in = 1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, sclk, sclk_oe_n, mosi, mosi_oe_n, miso, ss_out, ss_oe_n, irq, prev_sclk, pol, fpol;
  // Counters and expected receive words
  int miscompares = 0, n_checks = 0, cycles = 0, seed = 67, ratio, period, pcnt, sync_seen, pri, sec;
  logic [15:0] exp_rx[$];
  always #2.5 pclk = ~pclk;
  spicf_top DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_clock_pin_in(1'b0), .serial_clock_pin_out(sclk), .serial_clock_pin_oe_n(sclk_oe_n),
    .data_in_pin(miso), .data_out_pin(mosi), .data_out_oe_n(mosi_oe_n), .slave_select_pin_in(ss_in),
    .slave_select_pin_out(ss_out), .slave_select_pin_oe_n(ss_oe_n), .irq(irq));
  spicf_peer peer (.sclk(sclk), .pol(pol), .mosi(mosi), .miso(miso));
  // Leading edge spacing, sync activity and hang guard
  always @(posedge pclk) begin
    cycles++;
    pcnt++;
    if (sclk !== pol && prev_sclk === pol) begin
      period = pcnt;
      pcnt = 0;
    end
    prev_sclk = sclk;
    if (ss_out === fpol) sync_seen = 1;
    if (cycles > 60000) begin
      miscompares++;
      conclude();
    end
  end
  // One comparison
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One APB transfer; waits for pready with no bound of its own, only the hang guard
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // One word each way; done event polled under a bound
  task automatic xfer(input bit cmp);
    logic [15:0] t;
    logic [15:0] r;
    int n;
    t = $random(seed);
    r = $random(seed);
    peer.arm(r);
    if (cmp) exp_rx.push_back(r);
    apb(1, `SPICF_OFF_EVT_CLR, 32'h1);
    apb(1, `SPICF_OFF_DATA, {16'h0, t});
    n = 0;
    do begin
      apb(0, `SPICF_OFF_EVT, 0);
      n++;
    end while (q[0] !== 1'b1 && n < 3000);
    if (cmp) chk("sent word", t, peer.rx_word);
  endtask
  // Verdict
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    pol = 0;
    fpol = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, `SPICF_OFF_CTRL2, 0);
    chk("ctrl2 reset", 32'h0, q);
    apb(0, `SPICF_OFF_CTRL1, 0);
    chk("ctrl1 reset", 32'h0, q);
    apb(1, `SPICF_OFF_CTRL1, 32'hffffffff);
    apb(0, `SPICF_OFF_CTRL1, 0);
    chk("ctrl1 mask", 32'h1ff, q);
    // All ones is the unsupported ratio one; drop it before framing turns the clock on
    apb(1, `SPICF_OFF_CTRL1, 0);
    apb(1, `SPICF_OFF_CTRL2, 32'hffffffff);
    apb(0, `SPICF_OFF_CTRL2, 0);
    chk("ctrl2 mask", 32'he003, q);
    apb(0, 12'h01c, 0);
    chk("unmapped error", 1, e);
    chk("unmapped data", 0, q);
    apb(0, `SPICF_OFF_EVT_CLR, 0);
    chk("clear reads zero", 0, q);
    apb(1, `SPICF_OFF_CTRL2, 0);
    $display("test registers done");
    // Secondary values zero to six, then every primary ratio
    apb(1, `SPICF_OFF_EVT_EN, 32'h1);
    for (int i = 0; i < 10; i++) begin
      pri = i < 7 ? 3 : 9 - i;
      sec = i < 7 ? i : 6;
      pol = i[0];
      ratio = (8 - sec) * (pri == 3 ? 1 : pri == 2 ? 4 : pri == 1 ? 16 : 64);
      apb(1, `SPICF_OFF_CTRL1, 32'ha0 | (pol << 6) | (sec << 2) | pri);
      chk("clock idle", pol, sclk);
      chk("clock driven", 0, sclk_oe_n);
      chk("data driven", 0, mosi_oe_n);
      xfer(1);
      chk("bit period", ratio, period);
      chk("irq raised", 1, irq);
      apb(0, `SPICF_OFF_STAT, 0);
      chk("full set", 1, q[0]);
      apb(0, `SPICF_OFF_DATA, 0);
      chk("received", exp_rx.pop_front(), q);
      apb(0, `SPICF_OFF_STAT, 0);
      chk("full cleared", 0, q[0]);
    end
    apb(1, `SPICF_OFF_EVT_CLR, 32'h1);
    chk("irq cleared", 0, irq);
    $display("test divider done");
    // Masked event, then eight-entry buffer at ratio two
    pol = 0;
    apb(1, `SPICF_OFF_EVT_EN, 32'h0);
    apb(1, `SPICF_OFF_CTRL1, 32'hbb);
    apb(1, `SPICF_OFF_CTRL2, 32'h1);
    for (int k = 0; k < 8; k++) begin
      xfer(1);
      chk("irq masked", 0, irq);
      apb(0, `SPICF_OFF_STAT, 0);
      chk("buffer full", k == 7, q[0]);
    end
    for (int k = 0; k < 8; k++) begin
      apb(0, `SPICF_OFF_DATA, 0);
      chk("buffered word", exp_rx.pop_front(), q);
      apb(0, `SPICF_OFF_STAT, 0);
      chk("buffer freed", 0, q[0]);
    end
    $display("test buffer done");
    // Framed master, each polarity and sync edge; edge select kept clear
    for (int j = 0; j < 4; j++) begin
      fpol = j[0];
      apb(1, `SPICF_OFF_CTRL2, 32'h8000 | (fpol << 13) | (j[1] << 1));
      chk("sync driven", 0, ss_oe_n);
      chk("sync idle", !fpol, ss_out);
      sync_seen = 0;
      xfer(0);
      chk("sync pulse", 1, sync_seen);
      apb(0, `SPICF_OFF_DATA, 0);
    end
    apb(1, `SPICF_OFF_CTRL2, 32'hc000);
    chk("sync input", 1, ss_oe_n);
    $display("test framing done");
    conclude();
  end
endmodule
`default_nettype wire
